// ---- limiter_cfg_pkg.sv ----
`default_nettype none
package limiter_cfg_pkg;

  // Register offsets
  localparam logic [7:0] OFS_PLL_FRAC_LOW    = 8'h0A;
  localparam logic [7:0] OFS_KNEE_POINT      = 8'h0B;
  localparam logic [7:0] OFS_TRACK_GRADIENT  = 8'h0C;
  localparam logic [7:0] OFS_INIT_TUNING     = 8'h0D;
  localparam logic [7:0] OFS_ATTACK_HYST     = 8'h0E;
  localparam logic [7:0] OFS_RELEASE_RATE    = 8'h0F;
  localparam logic [7:0] OFS_INTEG_CTRL      = 8'h10;
  localparam logic [7:0] OFS_PDM_CONFIG      = 8'h11;
  localparam logic [7:0] OFS_INPUT_GAIN      = 8'h12;

  // Values after reset
  localparam logic [7:0] RST_PLL_FRAC_LOW    = 8'h00;
  localparam logic [7:0] RST_KNEE_POINT      = 8'h8F;
  localparam logic [7:0] RST_TRACK_GRADIENT  = 8'h80;
  localparam logic [7:0] RST_INIT_TUNING     = 8'hBE;
  localparam logic [7:0] RST_ATTACK_HYST     = 8'h08;
  localparam logic [7:0] RST_RELEASE_RATE    = 8'h04;
  localparam logic [7:0] RST_INTEG_CTRL      = 8'h00;
  localparam logic [7:0] RST_PDM_CONFIG      = 8'h01;
  localparam logic [7:0] RST_INPUT_GAIN      = 8'h00;

  // Field positions
  localparam int HYST_MSB      = 7;
  localparam int HYST_LSB      = 6;
  localparam int PBLK_MSB      = 4;
  localparam int PBLK_LSB      = 3;
  localparam int ATTACK_MSB    = 2;
  localparam int RELEASE_MSB   = 3;
  localparam int RATIO_MSB     = 7;
  localparam int RATIO_LSB     = 6;
  localparam int PEAK_MSB      = 5;
  localparam int EDGE_BIT      = 2;
  localparam int CLKSRC_MSB    = 1;
  localparam int GAIN_MSB      = 4;

  // Code limits
  localparam logic [13:0] PLL_FRAC_MAX    = 14'h270F;
  localparam logic [7:0]  KNEE_MIN_CODE   = 8'h6D;
  localparam logic [7:0]  KNEE_RSVD_CODE  = 8'hFF;

  // Rate arithmetic, units as named
  localparam logic [11:0] ATTACK_BASE_US  = 12'h014;
  localparam logic [11:0] ATTACK_STEP_US  = 12'h15E;
  localparam logic [10:0] RELEASE_BASE_MS = 11'h032;
  localparam logic [10:0] RELEASE_STEP_MS = 11'h069;
  // Gradient in units of 0.1 mV/V
  localparam logic [16:0] SLOPE_BASE      = 17'h0_2EE0;
  localparam logic [16:0] SLOPE_STEP      = 17'h0_0175;
  localparam logic [5:0]  GAIN_OFFSET_DB  = 6'h07;

  // Hysteresis in microvolts
  localparam logic [14:0] HYST_UV_1       = 15'h1108;
  localparam logic [14:0] HYST_UV_2       = 15'h3318;
  localparam logic [14:0] HYST_UV_3       = 15'h7738;

  // Battery code thresholds, 17.33 mV per step, 0x50 is 2.5 V
  localparam logic [7:0] VBAT_2V5        = 8'h50;
  localparam logic [7:0] VBAT_2V7        = 8'h5C;
  localparam logic [7:0] VBAT_2V9        = 8'h67;
  localparam logic [7:0] VBAT_3V1        = 8'h73;

  // PDM clock sources
  localparam logic [1:0] SRC_PLL_DIV8    = 2'h0;
  localparam logic [1:0] SRC_SENSE_CLK   = 2'h1;
  localparam logic [1:0] SRC_BIT_CLK     = 2'h2;
  localparam logic [1:0] SRC_MASTER_CLK  = 2'h3;
  localparam logic [1:0] PLL_DIV_HALF    = 2'h3;

endpackage : limiter_cfg_pkg
`default_nettype wire

// ---- integ_filter.sv ----
`timescale 1ns/1ps
`default_nettype none
module integ_filter (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       peak_over_i,
  input  wire logic       peak_under_i,
  input  wire logic [5:0] peak_limit_i,
  input  wire logic [1:0] weight_ratio_i,
  output logic            attack_trig_o,
  output logic            release_trig_o,
  output logic [5:0]      count_o
);

  logic [6:0] under_r;
  logic [6:0] under_goal;

  assign under_goal = 7'(1) << {weight_ratio_i, 1'b0};

  // Over-threshold peaks count up; reaching the limit fires an attack
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count_o        <= 6'h00;
      under_r        <= 7'h00;
      attack_trig_o  <= 1'b0;
      release_trig_o <= 1'b0;
    end else begin
      attack_trig_o  <= 1'b0;
      release_trig_o <= 1'b0;
      if (peak_over_i) begin
        under_r <= 7'h00;
        if (count_o + 6'h01 >= peak_limit_i || count_o == 6'h3F) begin // R11
          count_o       <= 6'h00;
          attack_trig_o <= 1'b1;
        end else begin
          count_o <= count_o + 6'h01;
        end
      end else if (peak_under_i) begin
        if (under_r + 7'h01 >= under_goal) begin // R12
          under_r <= 7'h00;
          if (count_o != 6'h00) begin
            count_o <= count_o - 6'h01;
          end
          release_trig_o <= (count_o <= 6'h01);
        end else begin
          under_r <= under_r + 7'h01;
        end
      end
    end
  end

endmodule : integ_filter
`default_nettype wire

// ---- pdm_clock_gen.sv ----
`timescale 1ns/1ps
`default_nettype none
module pdm_clock_gen (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [3:0] clk_pins_i,
  input  wire logic [1:0] source_i,
  input  wire logic       edge_choice_i,
  output logic            pdm_clk_o,
  output logic            ch1_launch_o,
  output logic            ch2_launch_o
);

  // Pin clocks are oversampled, so they must stay well below clk_i / 4
  logic [1:0] sync_r [4];
  logic [3:0] level;
  logic       pll_prev_r;
  logic [1:0] pll_cnt_r;
  logic       pll_div_r;
  logic       sel;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          sync_r[g] <= 2'h0;
        end else begin
          sync_r[g] <= {sync_r[g][0], clk_pins_i[g]};
        end
      end
      assign level[g] = sync_r[g][1];
    end
  endgenerate

  // PLL divided by 8: toggle every fourth rising edge
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pll_prev_r <= 1'b0;
      pll_cnt_r  <= 2'h0;
      pll_div_r  <= 1'b0;
    end else begin
      pll_prev_r <= level[0];
      if (level[0] && !pll_prev_r) begin
        pll_cnt_r <= pll_cnt_r + 2'h1;
        if (pll_cnt_r == limiter_cfg_pkg::PLL_DIV_HALF) begin
          pll_div_r <= !pll_div_r;
        end
      end
    end
  end

  always_comb begin
    unique case (source_i) // R15
      limiter_cfg_pkg::SRC_PLL_DIV8:   sel = pll_div_r;
      limiter_cfg_pkg::SRC_SENSE_CLK:  sel = level[1];
      limiter_cfg_pkg::SRC_BIT_CLK:    sel = level[2];
      limiter_cfg_pkg::SRC_MASTER_CLK: sel = level[3];
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pdm_clk_o    <= 1'b0;
      ch1_launch_o <= 1'b0;
      ch2_launch_o <= 1'b0;
    end else begin
      pdm_clk_o    <= sel;
      ch1_launch_o <= (sel != pdm_clk_o) && (sel == edge_choice_i); // R13
      ch2_launch_o <= (sel != pdm_clk_o) && (sel != edge_choice_i); // R14
    end
  end

endmodule : pdm_clock_gen
`default_nettype wire

// ---- battery_limiter_pdm_gain_regs.sv ----
// How it works
// R01: D is six upper plus eight lower bits
// R02: Multiplier applied only while PLL disabled
// R03: Knee code, 17.33 mV steps, reserved ends
// R04: Slope 1.2 V/V plus 0.0373 per step
// R05: Software writes 0xA9 to tuning register
// R06: Two-bit hysteresis before release re-arms
// R07: Software sets attack register bit five
// R08: Low battery blocks boost pass-through
// R09: Attack 20 us/dB plus 350 per step
// R10: Release 50 ms/dB plus 105 per step
// R11: Peak count limit gates gain changes
// R12: Decrement after four-power-ratio under counts
// R13: Edge bit picks channel one launch edge
// R14: Channel two launches on opposite edge
// R15: Two-bit PDM clock source, default sense
// R16: Gain code minus seven in dB
// R17: Software keeps reserved fields at defaults
`timescale 1ns/1ps
`default_nettype none
module battery_limiter_pdm_gain_regs (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Register port
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  output logic             reg_rdack_o,
  // PLL
  input  wire logic        pll_enable_i,
  input  wire logic [5:0]  pll_frac_high_i,
  output logic [13:0]      pll_mult_o,
  output logic             pll_mult_valid_o,
  // Battery tracking
  input  wire logic [7:0]  vbat_code_i,
  output logic [7:0]       knee_code_o,
  output logic             knee_valid_o,
  output logic [16:0]      slope_tenth_mvv_o,
  output logic [14:0]      hysteresis_uv_o,
  output logic             passthru_block_o,
  output logic [11:0]      attack_us_per_db_o,
  output logic [10:0]      release_ms_per_db_o,
  // Limiter integration
  input  wire logic        peak_over_i,
  input  wire logic        peak_under_i,
  output logic             attack_trig_o,
  output logic             release_trig_o,
  output logic [5:0]       integ_count_o,
  // PDM output timing
  input  wire logic        pll_clk_i,
  input  wire logic        sense_clock_input_i,
  input  wire logic        bclk_i,
  input  wire logic        mclk_i,
  output logic             pdm_clk_o,
  output logic             ch1_launch_o,
  output logic             ch2_launch_o,
  // Gain
  output logic signed [5:0] input_gain_db_o
);

  logic [7:0] pll_frac_low_r;
  logic [7:0] battery_knee_point_r;
  logic [7:0] battery_track_gradient_r;
  logic [7:0] reserved_init_tuning_r;
  logic [7:0] limiter_attack_hysteresis_r;
  logic [7:0] limiter_release_rate_r;
  logic [7:0] limiter_integration_control_r;
  logic [7:0] pdm_output_config_r;
  logic [7:0] input_gain_setting_r;

  logic [7:0]  rdata_nxt;
  logic [13:0] pll_frac_nxt;
  logic [7:0]  block_level;

  logic [1:0] hysteresis_sel;
  logic [1:0] passthru_block_level;
  logic [2:0] attack_code;
  logic [3:0] limiter_release_rate;
  logic [1:0] integ_weight_ratio;
  logic [5:0] integ_peak_limit;
  logic       pdm_edge_choice;
  logic [1:0] pdm_clock_source;
  logic [4:0] input_gain_code;

  assign hysteresis_sel =
    limiter_attack_hysteresis_r[limiter_cfg_pkg::HYST_MSB:
                                limiter_cfg_pkg::HYST_LSB];
  assign passthru_block_level =
    limiter_attack_hysteresis_r[limiter_cfg_pkg::PBLK_MSB:
                                limiter_cfg_pkg::PBLK_LSB];
  assign attack_code =
    limiter_attack_hysteresis_r[limiter_cfg_pkg::ATTACK_MSB:0];
  assign limiter_release_rate =
    limiter_release_rate_r[limiter_cfg_pkg::RELEASE_MSB:0];
  assign integ_weight_ratio =
    limiter_integration_control_r[limiter_cfg_pkg::RATIO_MSB:
                                  limiter_cfg_pkg::RATIO_LSB];
  assign integ_peak_limit =
    limiter_integration_control_r[limiter_cfg_pkg::PEAK_MSB:0];
  assign pdm_edge_choice  = pdm_output_config_r[limiter_cfg_pkg::EDGE_BIT];
  assign pdm_clock_source =
    pdm_output_config_r[limiter_cfg_pkg::CLKSRC_MSB:0];
  assign input_gain_code  = input_gain_setting_r[limiter_cfg_pkg::GAIN_MSB:0];

  // Reserved fields are plain storage; software keeps their defaults
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pll_frac_low_r                <= limiter_cfg_pkg::RST_PLL_FRAC_LOW;
      battery_knee_point_r          <= limiter_cfg_pkg::RST_KNEE_POINT;
      battery_track_gradient_r      <= limiter_cfg_pkg::RST_TRACK_GRADIENT;
      reserved_init_tuning_r        <= limiter_cfg_pkg::RST_INIT_TUNING;
      limiter_attack_hysteresis_r   <= limiter_cfg_pkg::RST_ATTACK_HYST;
      limiter_release_rate_r        <= limiter_cfg_pkg::RST_RELEASE_RATE;
      limiter_integration_control_r <= limiter_cfg_pkg::RST_INTEG_CTRL;
      pdm_output_config_r           <= limiter_cfg_pkg::RST_PDM_CONFIG;
      input_gain_setting_r          <= limiter_cfg_pkg::RST_INPUT_GAIN;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        limiter_cfg_pkg::OFS_PLL_FRAC_LOW:
          pll_frac_low_r <= reg_wdata_i;
        limiter_cfg_pkg::OFS_KNEE_POINT:
          battery_knee_point_r <= reg_wdata_i;
        limiter_cfg_pkg::OFS_TRACK_GRADIENT:
          battery_track_gradient_r <= reg_wdata_i;
        limiter_cfg_pkg::OFS_INIT_TUNING:
          reserved_init_tuning_r <= reg_wdata_i; // R05
        limiter_cfg_pkg::OFS_ATTACK_HYST:
          limiter_attack_hysteresis_r <= reg_wdata_i; // R07
        limiter_cfg_pkg::OFS_RELEASE_RATE:
          limiter_release_rate_r <= reg_wdata_i; // R17
        limiter_cfg_pkg::OFS_INTEG_CTRL:
          limiter_integration_control_r <= reg_wdata_i;
        limiter_cfg_pkg::OFS_PDM_CONFIG:
          pdm_output_config_r <= reg_wdata_i;
        limiter_cfg_pkg::OFS_INPUT_GAIN:
          input_gain_setting_r <= reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_comb begin
    unique case (reg_addr_i)
      limiter_cfg_pkg::OFS_PLL_FRAC_LOW:   rdata_nxt = pll_frac_low_r;
      limiter_cfg_pkg::OFS_KNEE_POINT:     rdata_nxt = battery_knee_point_r;
      limiter_cfg_pkg::OFS_TRACK_GRADIENT:
        rdata_nxt = battery_track_gradient_r;
      limiter_cfg_pkg::OFS_INIT_TUNING:    rdata_nxt = reserved_init_tuning_r;
      limiter_cfg_pkg::OFS_ATTACK_HYST:
        rdata_nxt = limiter_attack_hysteresis_r;
      limiter_cfg_pkg::OFS_RELEASE_RATE:   rdata_nxt = limiter_release_rate_r;
      limiter_cfg_pkg::OFS_INTEG_CTRL:
        rdata_nxt = limiter_integration_control_r;
      limiter_cfg_pkg::OFS_PDM_CONFIG:     rdata_nxt = pdm_output_config_r;
      limiter_cfg_pkg::OFS_INPUT_GAIN:     rdata_nxt = input_gain_setting_r;
      default:                             rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      reg_rdata_o <= 8'h00;
      reg_rdack_o <= 1'b0;
    end else begin
      reg_rdack_o <= reg_rd_i;
      if (reg_rd_i) begin
        reg_rdata_o <= rdata_nxt;
      end
    end
  end

  assign pll_frac_nxt = {pll_frac_high_i, pll_frac_low_r}; // R01

  // A running PLL keeps its multiplier so half-written values stay out
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pll_mult_o       <= 14'h0000;
      pll_mult_valid_o <= 1'b1;
    end else if (!pll_enable_i) begin // R02
      pll_mult_o       <= pll_frac_nxt; // R01
      pll_mult_valid_o <= (pll_frac_nxt <= limiter_cfg_pkg::PLL_FRAC_MAX);
    end
  end

  always_comb begin
    unique case (passthru_block_level) // R08
      2'h0: block_level = limiter_cfg_pkg::VBAT_2V5;
      2'h1: block_level = limiter_cfg_pkg::VBAT_2V7;
      2'h2: block_level = limiter_cfg_pkg::VBAT_2V9;
      2'h3: block_level = limiter_cfg_pkg::VBAT_3V1;
    endcase
  end

  // Blocking pass-through keeps the boost running regardless of output
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      passthru_block_o <= 1'b0;
    end else begin
      passthru_block_o <= (vbat_code_i < block_level); // R08
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      knee_code_o  <= limiter_cfg_pkg::RST_KNEE_POINT;
      knee_valid_o <= 1'b1;
    end else begin
      knee_code_o  <= battery_knee_point_r; // R03
      knee_valid_o <= (battery_knee_point_r >= limiter_cfg_pkg::KNEE_MIN_CODE)
        && (battery_knee_point_r != limiter_cfg_pkg::KNEE_RSVD_CODE);
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      slope_tenth_mvv_o <= limiter_cfg_pkg::SLOPE_BASE;
    end else begin
      slope_tenth_mvv_o <= 17'(limiter_cfg_pkg::SLOPE_BASE // R04
        + limiter_cfg_pkg::SLOPE_STEP * {9'h000, battery_track_gradient_r});
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      hysteresis_uv_o <= 15'h0000;
    end else begin
      unique case (hysteresis_sel) // R06
        2'h0: hysteresis_uv_o <= 15'h0000;
        2'h1: hysteresis_uv_o <= limiter_cfg_pkg::HYST_UV_1;
        2'h2: hysteresis_uv_o <= limiter_cfg_pkg::HYST_UV_2;
        2'h3: hysteresis_uv_o <= limiter_cfg_pkg::HYST_UV_3;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      attack_us_per_db_o  <= limiter_cfg_pkg::ATTACK_BASE_US;
      release_ms_per_db_o <= limiter_cfg_pkg::RELEASE_BASE_MS;
    end else begin
      attack_us_per_db_o  <= 12'(limiter_cfg_pkg::ATTACK_BASE_US
        + limiter_cfg_pkg::ATTACK_STEP_US * {9'h000, attack_code}); // R09
      release_ms_per_db_o <= 11'(limiter_cfg_pkg::RELEASE_BASE_MS
        + limiter_cfg_pkg::RELEASE_STEP_MS
          * {7'h00, limiter_release_rate}); // R10
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      input_gain_db_o <= -6'sd7;
    end else begin
      input_gain_db_o <= $signed({1'b0, input_gain_code}
                                 - limiter_cfg_pkg::GAIN_OFFSET_DB); // R16
    end
  end

  integ_filter u_integ (
    .clk_i          (clk_i),
    .rstn_i         (rstn_i),
    .peak_over_i    (peak_over_i),
    .peak_under_i   (peak_under_i),
    .peak_limit_i   (integ_peak_limit),   // R11
    .weight_ratio_i (integ_weight_ratio), // R12
    .attack_trig_o  (attack_trig_o),
    .release_trig_o (release_trig_o),
    .count_o        (integ_count_o)
  );

  pdm_clock_gen u_pdm (
    .clk_i         (clk_i),
    .rstn_i        (rstn_i),
    .clk_pins_i    ({mclk_i, bclk_i, sense_clock_input_i, pll_clk_i}),
    .source_i      (pdm_clock_source), // R15
    .edge_choice_i (pdm_edge_choice),  // R13
    .pdm_clk_o     (pdm_clk_o),
    .ch1_launch_o  (ch1_launch_o),
    .ch2_launch_o  (ch2_launch_o)      // R14
  );

endmodule : battery_limiter_pdm_gain_regs
`default_nettype wire

// ---- battery_limiter_pdm_gain_regs_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module battery_limiter_pdm_gain_regs_props (
  input wire logic              clk_i,
  input wire logic              rstn_i,
  input wire logic [7:0]        reg_addr_i,
  input wire logic [7:0]        reg_wdata_i,
  input wire logic              reg_wr_i,
  input wire logic              reg_rd_i,
  input wire logic [7:0]        reg_rdata_o,
  input wire logic              reg_rdack_o,
  input wire logic              pll_enable_i,
  input wire logic [5:0]        pll_frac_high_i,
  input wire logic [13:0]       pll_mult_o,
  input wire logic              pll_mult_valid_o,
  input wire logic [7:0]        knee_code_o,
  input wire logic              knee_valid_o,
  input wire logic [11:0]       attack_us_per_db_o,
  input wire logic [10:0]       release_ms_per_db_o,
  input wire logic              attack_trig_o,
  input wire logic              release_trig_o,
  input wire logic              pdm_clk_o,
  input wire logic              ch1_launch_o,
  input wire logic              ch2_launch_o,
  input wire logic signed [5:0] input_gain_db_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_rd_ack;
    reg_rdack_o == $past(reg_rd_i);
  endproperty
  a_rd_ack: assert property (p_rd_ack) else $error("read ack missing");
  property p_unmapped;
    reg_rd_i && (reg_addr_i < 8'h0A || reg_addr_i > 8'h12)
      |=> reg_rdata_o == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read data");
  property p_gain;
    reg_wr_i && reg_addr_i == 8'h12 |-> ##2 input_gain_db_o ==
      $signed({1'b0, $past(reg_wdata_i[4:0], 2)}) - 6'sh07;
  endproperty
  a_gain: assert property (p_gain) else $error("gain mismatch");
  property p_attack;
    reg_wr_i && reg_addr_i == 8'h0E |-> ##2 attack_us_per_db_o ==
      12'h014 + 12'h15E * {9'h000, $past(reg_wdata_i[2:0], 2)};
  endproperty
  a_attack: assert property (p_attack) else $error("attack rate");
  property p_release;
    reg_wr_i && reg_addr_i == 8'h0F |-> ##2 release_ms_per_db_o ==
      11'h032 + 11'h069 * {7'h00, $past(reg_wdata_i[3:0], 2)};
  endproperty
  a_release: assert property (p_release) else $error("release rate");
  property p_pll_hold;
    pll_enable_i && $past(pll_enable_i) |-> $stable(pll_mult_o);
  endproperty
  a_pll_hold: assert property (p_pll_hold) else $error("pll moved");
  property p_pll_follow;
    !pll_enable_i |=> pll_mult_o[13:8] == $past(pll_frac_high_i);
  endproperty
  a_pll_follow: assert property (p_pll_follow) else $error("pll high");
  property p_pll_valid;
    pll_mult_valid_o == (pll_mult_o <= 14'h270F);
  endproperty
  a_pll_valid: assert property (p_pll_valid) else $error("pll valid");
  property p_knee_valid;
    knee_valid_o == (knee_code_o >= 8'h6D && knee_code_o != 8'hFF);
  endproperty
  a_knee_valid: assert property (p_knee_valid) else $error("knee");
  property p_launch_edge;
    ch1_launch_o || ch2_launch_o |-> pdm_clk_o != $past(pdm_clk_o);
  endproperty
  a_launch_edge: assert property (p_launch_edge) else $error("launch");
  property p_launch_apart;
    ch1_launch_o |-> !ch2_launch_o;
  endproperty
  a_launch_apart: assert property (p_launch_apart) else $error("both");
  c_attack: cover property (attack_trig_o);
  c_release: cover property (release_trig_o);
  c_launch: cover property (ch1_launch_o);
  c_read: cover property (reg_rdack_o);
endmodule : battery_limiter_pdm_gain_regs_props

bind battery_limiter_pdm_gain_regs battery_limiter_pdm_gain_regs_props
  battery_limiter_pdm_gain_regs_props_inst (.clk_i, .rstn_i, .reg_addr_i,
  .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .reg_rdack_o,
  .pll_enable_i, .pll_frac_high_i, .pll_mult_o, .pll_mult_valid_o,
  .knee_code_o, .knee_valid_o, .attack_us_per_db_o, .release_ms_per_db_o,
  .attack_trig_o, .release_trig_o, .pdm_clk_o, .ch1_launch_o, .ch2_launch_o,
  .input_gain_db_o);
`default_nettype wire

// ---- battery_limiter_pdm_gain_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module battery_limiter_pdm_gain_regs_tb_top;
  logic        clk_i, rstn_i, reg_wr_i, reg_rd_i, reg_rdack_o, pll_enable_i;
  logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, vbat_code_i, knee_code_o;
  logic [5:0]  pll_frac_high_i, integ_count_o;
  logic [13:0] pll_mult_o;
  logic [16:0] slope_tenth_mvv_o;
  logic [14:0] hysteresis_uv_o;
  logic [11:0] attack_us_per_db_o;
  logic [10:0] release_ms_per_db_o;
  logic        pll_mult_valid_o, knee_valid_o, passthru_block_o, pdm_clk_o;
  logic        peak_over_i, peak_under_i, attack_trig_o, release_trig_o;
  logic        pll_clk_i, sense_clock_input_i, bclk_i, mclk_i;
  logic        ch1_launch_o, ch2_launch_o, pdm_on, pdm_edge, pdm_prev;
  logic signed [5:0] input_gain_db_o;
  int          miscompares, n_compared, n_att, n_rel, n_rise;

  battery_limiter_pdm_gain_regs battery_limiter_pdm_gain_regs_inst (.clk_i,
    .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .reg_rdack_o, .pll_enable_i, .pll_frac_high_i, .pll_mult_o,
    .pll_mult_valid_o, .vbat_code_i, .knee_code_o, .knee_valid_o,
    .slope_tenth_mvv_o, .hysteresis_uv_o, .passthru_block_o,
    .attack_us_per_db_o, .release_ms_per_db_o, .peak_over_i, .peak_under_i,
    .attack_trig_o, .release_trig_o, .integ_count_o, .pll_clk_i,
    .sense_clock_input_i, .bclk_i, .mclk_i, .pdm_clk_o, .ch1_launch_o,
    .ch2_launch_o, .input_gain_db_o);

  // Source clocks kept below a quarter of clk_i so the synchroniser sees all
  initial begin clk_i = 1'b0; forever #5 clk_i = ~clk_i; end
  always #25 pll_clk_i = ~pll_clk_i;
  always #50 sense_clock_input_i = ~sense_clock_input_i;
  always #80 bclk_i = ~bclk_i;
  always #120 mclk_i = ~mclk_i;

  task automatic chk(input string n, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk

  always @(posedge clk_i) begin
    if (attack_trig_o === 1'b1) n_att++;
    if (release_trig_o === 1'b1) n_rel++;
    if (pdm_on && pdm_clk_o === 1'b1 && pdm_prev === 1'b0) n_rise++;
    pdm_prev <= pdm_clk_o;
    if (pdm_on && ch1_launch_o === 1'b1)
      chk("ch1_clk", pdm_edge, pdm_clk_o);
    if (pdm_on && ch2_launch_o === 1'b1)
      chk("ch2_clk", !pdm_edge, pdm_clk_o);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    tick(1);
    reg_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    tick(1);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    tick(1);
    reg_rd_i = 1'b0;
    chk("rdack", 1, reg_rdack_o);
    chk("rdata", e, reg_rdata_o);
  endtask : rd

  task automatic pk(input logic over);
    tick(1);
    peak_over_i = over;
    peak_under_i = !over;
    tick(1);
    peak_over_i = 1'b0;
    peak_under_i = 1'b0;
  endtask : pk

  task automatic t_reset;
    logic [7:0] rv [9] = '{8'h00, 8'h8F, 8'h80, 8'hBE, 8'h08, 8'h04, 8'h00,
                           8'h01, 8'h00};
    for (int i = 0; i < 9; i++) rd(8'h0A + 8'(i), rv[i]);
    chk("slope", 12000 + 373 * 128, slope_tenth_mvv_o);
    chk("attack", 20, attack_us_per_db_o);
    chk("release", 50 + 105 * 4, release_ms_per_db_o);
    chk("gain", -7, input_gain_db_o);
    chk("knee_valid", 1, knee_valid_o);
    for (int i = 0; i < 9; i++) wr(8'h0A + 8'(i), 8'hA5 ^ 8'(i));
    for (int i = 0; i < 9; i++) rd(8'h0A + 8'(i), 8'hA5 ^ 8'(i));
    wr(8'h13, 8'hFF);
    rd(8'h13, 8'h00);
    rd(8'h09, 8'h00);
    $display("test reset_and_access done");
  endtask : t_reset

  task automatic t_fields;
    int hy [4] = '{0, 4360, 13080, 30520};
    logic [7:0] th [4] = '{8'h50, 8'h5C, 8'h67, 8'h73};
    logic [7:0] kc [4] = '{8'h6C, 8'h6D, 8'hFE, 8'hFF};
    wr(8'h0D, 8'hA9);
    for (int i = 0; i < 8; i++) begin
      wr(8'h0E, {2'(i), 1'b1, 2'(i), 3'(i)});
      tick(2);
      chk("attack", 20 + 350 * i, attack_us_per_db_o);
      chk("hyst", hy[i % 4], hysteresis_uv_o);
    end
    for (int i = 0; i < 16; i++) begin
      wr(8'h0F, 8'(i));
      tick(2);
      chk("release", 50 + 105 * i, release_ms_per_db_o);
    end
    for (int i = 0; i < 4; i++) begin
      wr(8'h0E, {3'h1, 2'(i), 3'h0});
      vbat_code_i = th[i] - 8'h01;
      tick(3);
      chk("block_low", 1, passthru_block_o);
      vbat_code_i = th[i];
      tick(3);
      chk("block_ok", 0, passthru_block_o);
      wr(8'h0B, kc[i]);
      tick(2);
      chk("knee", kc[i], knee_code_o);
      chk("knee_valid", i == 1 || i == 2, knee_valid_o);
    end
    for (int c = 0; c < 256; c += 85) begin
      wr(8'h0C, 8'(c));
      wr(8'h12, 8'(c % 32));
      tick(2);
      chk("slope", 12000 + 373 * c, slope_tenth_mvv_o);
      chk("gain", 6'(c % 32) - 6'h07, input_gain_db_o);
    end
    $display("test field_decode done");
  endtask : t_fields

  task automatic t_pll;
    pll_frac_high_i = 6'h27;
    wr(8'h0A, 8'h0F);
    tick(2);
    chk("pll_mult", 14'h270F, pll_mult_o);
    chk("pll_valid", 1, pll_mult_valid_o);
    wr(8'h0A, 8'h10);
    tick(2);
    chk("pll_valid", 0, pll_mult_valid_o);
    pll_enable_i = 1'b1;
    wr(8'h0A, 8'h00);
    pll_frac_high_i = 6'h01;
    tick(3);
    chk("pll_frozen", 14'h2710, pll_mult_o);
    pll_enable_i = 1'b0;
    tick(3);
    chk("pll_applied", 14'h0100, pll_mult_o);
    $display("test pll_update done");
  endtask : t_pll

  task automatic t_integ;
    wr(8'h10, 8'h42);
    n_att = 0;
    n_rel = 0;
    repeat (2) pk(1'b1);
    tick(3);
    chk("attack_trigs", 1, n_att);
    chk("count", 0, integ_count_o);
    pk(1'b1);
    repeat (3) pk(1'b0);
    tick(3);
    chk("count_held", 1, integ_count_o);
    pk(1'b0);
    tick(3);
    chk("count_down", 0, integ_count_o);
    chk("release_trigs", 1, n_rel);
    wr(8'h10, 8'h00);
    pk(1'b1);
    tick(3);
    chk("attack_trigs", 2, n_att);
    $display("test integration done");
  endtask : t_integ

  task automatic t_pdm;
    int er [4] = '{12, 48, 30, 20};
    for (int s = 0; s < 4; s++) begin
      pdm_edge = s[0];
      wr(8'h11, {5'h00, s[0], 2'(s)});
      tick(20);
      n_rise = 0;
      pdm_on = 1'b1;
      #4800;
      pdm_on = 1'b0;
      chk("pdm_rises", 1, n_rise >= er[s] - 1 && n_rise <= er[s] + 1);
    end
    $display("test pdm_clocking done");
  endtask : t_pdm

  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  // The whole sequence needs about 23 us; allow about thirteen times that
  initial begin
    #300000;
    miscompares++;
    print_verdict();
  end

  initial begin
    {rstn_i, reg_wr_i, reg_rd_i, pll_enable_i, peak_over_i, peak_under_i} = '0;
    {reg_addr_i, reg_wdata_i, pll_frac_high_i, pdm_on, pdm_edge} = '0;
    vbat_code_i = 8'hA0;
    {pll_clk_i, sense_clock_input_i, bclk_i, mclk_i} = '0;
    repeat (4) @(posedge clk_i);
    #1;
    rstn_i = 1'b1;
    t_reset();
    t_fields();
    t_pll();
    t_integ();
    t_pdm();
    print_verdict();
  end
endmodule : battery_limiter_pdm_gain_regs_tb_top
`default_nettype wire
